// >>> hw/rss_pkg.sv
// rss_pkg: shared constants and types for the reset and sleep sequencer
// assumes one 100 MHz clock, 4-bit register data, plain register port
package rss_pkg;

    // ==========================================
    // register port
    localparam int DATA_W = 4;
    localparam int ADDR_W = 3;
    localparam logic [ADDR_W-1:0] REG_SYS_CTL_ONE = 3'h0;
    localparam logic [ADDR_W-1:0] REG_SYS_CTL_TWO = 3'h1;
    localparam logic [ADDR_W-1:0] REG_SYS_CTL_THREE = 3'h2;
    localparam logic [ADDR_W-1:0] REG_COMBO_SEL_ONE = 3'h3;
    localparam logic [ADDR_W-1:0] REG_COMBO_SEL_TWO = 3'h4;
    localparam logic [ADDR_W-1:0] REG_PORT_B_OPT = 3'h5;
    localparam logic [ADDR_W-1:0] REG_PORT_C_STROBE = 3'h6;

    // ==========================================
    // field positions and reset values
    localparam int SLEEP_BIT = 0;
    localparam int GUARD_BIT = 2;
    localparam int OSC_DIS_BIT = 1;
    localparam int WAKE_COMBO_BIT = 0;
    localparam int PORT_B_PULL_BIT = 1;
    localparam int STROBE_SEL_LSB = 0;
    localparam int STROBE_SEL_W = 2;
    localparam logic [STROBE_SEL_W-1:0] STROBE_SHOWS_RESET = 2'h0;
    localparam logic [DATA_W-1:0] OPTION_RESET = 4'h0;
    localparam logic [DATA_W-1:0] READ_ZERO = 4'h0;

    // ==========================================
    // timing
    localparam int CLK_HZ = 100_000_000;
    localparam int PIN_DEBOUNCE_MS = 16;
    localparam int WAKE_PULSE_US = 10;
    localparam int DEBOUNCE_CYC = PIN_DEBOUNCE_MS * (CLK_HZ / 1000);
    localparam int WAKE_CYC = WAKE_PULSE_US * (CLK_HZ / 1_000_000);
    localparam int CPU_DELAY_TICKS = 32768;
    localparam int SYS_RESET_TICKS = 8;
    localparam int OSC_LOSS_CYC = CLK_HZ / 16384;

    // ==========================================
    // types
    typedef enum logic {MODE_ACTIVE, MODE_SLEEP} rss_mode_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } rss_bus_s;

    typedef struct packed {
        logic oscEnable;
        logic portBHighZ;
        logic portBPull;
        logic portAEnable;
        logic portAPullDown;
        logic interruptsOn;
        logic oscSupervisorOn;
    } rss_sleep_ctl_s;

endpackage : rss_pkg

// >>> hw/rss_level_filter.sv
// rss_level_filter: reports a level once it has stood high for CYCLES clocks
// assumes level is already synchronous to mclk
`timescale 1ns/1ps
module rss_level_filter
#(
    parameter int CYCLES = 16
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // level in, gated
    input wire logic enable,
    input wire logic level,
    // filtered level
    output logic held
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count_q;

    // ==========================================
    // stable-high counter
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            count_q <= '0;
            held <= 1'b0;
        end
        else if (!enable || !level)
        begin
            count_q <= '0;
            held <= 1'b0;
        end
        else if (count_q == LAST)
        begin
            held <= 1'b1;
        end
        else
        begin
            count_q <= count_q + 1'b1;
        end
    end
endmodule : rss_level_filter

// >>> hw/rss_combo_match.sv
// rss_combo_match: port line combination compare, and or or type
// assumes lines are synchronous to the caller's clock
`timescale 1ns/1ps
module rss_combo_match
#(
    parameter bit OR_TYPE = 1'b0
)
(
    // selections
    input wire logic [3:0] selOne,
    input wire logic [3:0] selTwo,
    // port lines
    input wire logic [3:0] lines,
    // result
    output logic match
);
    logic [3:0] terms;

    // ==========================================
    // per-line terms and merge
    always_comb
    begin
        terms = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            terms[i] = selOne[i] ? (selTwo[i] | ~lines[i]) : (selTwo[i] & lines[i]);
        end
        match = OR_TYPE ? (|terms) : (&terms);
    end
endmodule : rss_combo_match

// >>> hw/rss_reset_sleep_sequencer.sv
// rss_reset_sleep_sequencer: sleep entry and wake, reset merging and delays
// assumes resetn is the power-on reset, pins are asynchronous to mclk,
// systemClockTap toggles at the system clock rate while the oscillator runs
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps

module rss_reset_sleep_sequencer
    import rss_pkg::*;
#(
    parameter bit OR_TYPE = 1'b0,
    parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
    parameter int WAKE_CYCLES = WAKE_CYC,
    parameter int OSC_LOSS_CYCLES = OSC_LOSS_CYC,
    parameter int CPU_DELAY = CPU_DELAY_TICKS,
    parameter int SYS_HOLD = SYS_RESET_TICKS
)
(
    // clock and power-on reset
    input wire logic mclk,
    input wire logic resetn,
    // register port
    input wire rss_bus_s busIn,
    output logic [DATA_W-1:0] rdata_q,
    // pins
    input wire logic resetPin,
    input wire logic [3:0] inputPortLine,
    input wire logic systemClockTap,
    // same-clock sources
    input wire logic wdogReset,
    input wire logic strobeData,
    // outputs
    output logic sysReset_q,
    output logic cpuReset_q,
    output logic strobePin_q,
    output logic sleepMode_q,
    output rss_sleep_ctl_s sleepCtl_q
);
    localparam int HW = $clog2(SYS_HOLD + 1);
    localparam int DW = $clog2(CPU_DELAY + 1);
    localparam int OW = $clog2(OSC_LOSS_CYCLES + 1);
    localparam logic [HW-1:0] HOLD_LOAD = HW'(SYS_HOLD);
    localparam logic [DW-1:0] DELAY_LOAD = DW'(CPU_DELAY);
    localparam logic [OW-1:0] OSC_LAST = OW'(OSC_LOSS_CYCLES - 1);

    rss_mode_e mode_q;
    logic [5:0] sync1_q, sync2_q, sync3_q, filt_q;
    logic tapPrev_q, sysTick;
    logic [OW-1:0] oscIdle_q;
    logic oscLost_q, supervise;
    logic comboMatch, comboMatch_q;
    logic pinHeld, comboHeld, wakeHeld;
    logic sleepWrite, wakeNow, srcAny;
    logic sleepFlag_q, guard_q, oscDisable_q, wakeOpt_q, portBPull_q, wakeDelay_q;
    logic [3:0] comboSelOne_q, comboSelTwo_q;
    logic [STROBE_SEL_W-1:0] strobeSel_q;
    logic [HW-1:0] holdCnt_q;
    logic [DW-1:0] cpuCnt_q;

    // ==========================================
    // pin synchronisers, change taken when stages two and three agree
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
            sync3_q <= 6'h00;
            filt_q <= 6'h00;
        end
        else
        begin
            sync1_q <= {systemClockTap, resetPin, inputPortLine};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            filt_q <= (sync2_q & sync3_q) | (filt_q & (sync2_q | sync3_q));
        end
    end

    // ==========================================
    // system clock tick from the tap
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            tapPrev_q <= 1'b0;
        else
            tapPrev_q <= filt_q[5];
    end

    assign sysTick = filt_q[5] & ~tapPrev_q;

    // ==========================================
    // oscillation supervisor
    // off during wake delay
    assign supervise = (mode_q == MODE_ACTIVE) && !oscDisable_q && !wakeDelay_q;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            oscIdle_q <= '0;
            oscLost_q <= 1'b0;
        end
        else if (!supervise || sysTick)
        begin
            oscIdle_q <= '0;
            oscLost_q <= 1'b0;
        end
        else if (oscIdle_q == OSC_LAST)
            oscLost_q <= 1'b1;
        else
            oscIdle_q <= oscIdle_q + 1'b1;
    end

    // ==========================================
    // port combination and pin filters
    rss_combo_match #(.OR_TYPE(OR_TYPE)) u_match
    (
        .selOne(comboSelOne_q),
        .selTwo(comboSelTwo_q),
        .lines(filt_q[3:0]),
        .match(comboMatch)
    );

    // port lines ignored in sleep without option
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            comboMatch_q <= 1'b0;
        else
            comboMatch_q <= comboMatch && (mode_q == MODE_ACTIVE || wakeOpt_q);
    end

    rss_level_filter #(.CYCLES(DEBOUNCE_CYCLES)) u_pin_deb
    (
        .mclk(mclk),
        .resetn(resetn),
        .enable(mode_q == MODE_ACTIVE),
        .level(filt_q[4]),
        .held(pinHeld)
    );

    rss_level_filter #(.CYCLES(DEBOUNCE_CYCLES)) u_combo_deb
    (
        .mclk(mclk),
        .resetn(resetn),
        .enable(mode_q == MODE_ACTIVE),
        .level(comboMatch_q),
        .held(comboHeld)
    );

    rss_level_filter #(.CYCLES(WAKE_CYCLES)) u_wake
    (
        .mclk(mclk),
        .resetn(resetn),
        .enable(mode_q == MODE_SLEEP),
        .level(filt_q[4]),
        .held(wakeHeld)
    );

    // ==========================================
    // sleep mode
    // guarded sleep write
    assign sleepWrite = busIn.wr && busIn.addr == REG_SYS_CTL_ONE
        && busIn.wdata[SLEEP_BIT] && guard_q;
    assign wakeNow = wakeHeld || (comboMatch_q && wakeOpt_q);

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            mode_q <= MODE_ACTIVE;
            sleepFlag_q <= 1'b0;
        end
        else
        begin
            unique case (mode_q)
                MODE_ACTIVE:
                begin
                    if (sleepWrite)
                    begin
                        mode_q <= MODE_SLEEP;
                        sleepFlag_q <= 1'b1;
                    end
                end
                MODE_SLEEP:
                begin
                    if (wakeNow)
                    begin
                        mode_q <= MODE_ACTIVE;
                        sleepFlag_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // power-on only registers, then the oscillator disable bit, also cleared by system reset
    // cleared by power-on only
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            guard_q <= 1'b0;
            comboSelOne_q <= OPTION_RESET;
            comboSelTwo_q <= OPTION_RESET;
            wakeOpt_q <= 1'b0;
            portBPull_q <= 1'b0;
            strobeSel_q <= STROBE_SHOWS_RESET;
        end
        else if (busIn.wr)
        begin
            unique case (busIn.addr)
                REG_SYS_CTL_TWO: guard_q <= busIn.wdata[GUARD_BIT];
                REG_COMBO_SEL_ONE: comboSelOne_q <= busIn.wdata;
                REG_COMBO_SEL_TWO: comboSelTwo_q <= busIn.wdata;
                REG_PORT_B_OPT:
                begin
                    wakeOpt_q <= busIn.wdata[WAKE_COMBO_BIT];
                    portBPull_q <= busIn.wdata[PORT_B_PULL_BIT];
                end
                REG_PORT_C_STROBE:
                    strobeSel_q <= busIn.wdata[STROBE_SEL_LSB +: STROBE_SEL_W];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            oscDisable_q <= 1'b0;
        else if (sysReset_q)
            oscDisable_q <= 1'b0;
        else if (busIn.wr && busIn.addr == REG_SYS_CTL_THREE)
            oscDisable_q <= busIn.wdata[OSC_DIS_BIT];
    end

    // ==========================================
    // system reset with hold
    // five sources merged
    assign srcAny = (mode_q == MODE_SLEEP) || pinHeld || comboHeld || wdogReset || oscLost_q;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            sysReset_q <= 1'b1;
            holdCnt_q <= HOLD_LOAD;
        end
        else if (srcAny)
        begin
            sysReset_q <= 1'b1;
            holdCnt_q <= HOLD_LOAD;
        end
        else if (holdCnt_q == '0)
            sysReset_q <= 1'b0;
        else if (sysTick)
            holdCnt_q <= holdCnt_q - 1'b1;
    end

    // ==========================================
    // CPU reset delay
    // delay after system reset
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            cpuReset_q <= 1'b1;
            cpuCnt_q <= DELAY_LOAD;
        end
        else if (sysReset_q)
        begin
            cpuReset_q <= 1'b1;
            cpuCnt_q <= DELAY_LOAD;
        end
        else if (cpuCnt_q == '0)
            cpuReset_q <= 1'b0;
        else if (sysTick)
            cpuCnt_q <= cpuCnt_q - 1'b1;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            wakeDelay_q <= 1'b0;
        else if (mode_q == MODE_SLEEP && wakeNow)
            wakeDelay_q <= 1'b1;
        else if (!sysReset_q && cpuCnt_q == '0)
            wakeDelay_q <= 1'b0;
    end

    // ==========================================
    // sleep-state outputs
    // oscillator off
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            sleepCtl_q <= '0;
            sleepMode_q <= 1'b0;
        end
        else
        begin
            sleepMode_q <= (mode_q == MODE_SLEEP);
            sleepCtl_q.oscEnable <= (mode_q == MODE_ACTIVE);
            sleepCtl_q.portBHighZ <= (mode_q == MODE_SLEEP);
            sleepCtl_q.portBPull <= (mode_q == MODE_SLEEP) && portBPull_q;
            sleepCtl_q.portAEnable <= (mode_q == MODE_ACTIVE) || wakeOpt_q;
            sleepCtl_q.portAPullDown <= (mode_q == MODE_ACTIVE) || wakeOpt_q;
            sleepCtl_q.interruptsOn <= (mode_q == MODE_ACTIVE);
            sleepCtl_q.oscSupervisorOn <= supervise;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            strobePin_q <= 1'b1;
        else if (strobeSel_q == STROBE_SHOWS_RESET)
            strobePin_q <= cpuReset_q;
        else
            strobePin_q <= strobeData;
    end

    // ==========================================
    // register read
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            rdata_q <= READ_ZERO;
        else if (!busIn.rd)
            rdata_q <= READ_ZERO;
        else
        begin
            rdata_q <= READ_ZERO;
            unique case (busIn.addr)
                REG_SYS_CTL_ONE: rdata_q[SLEEP_BIT] <= sleepFlag_q;
                REG_SYS_CTL_TWO: rdata_q[GUARD_BIT] <= guard_q;
                REG_SYS_CTL_THREE: rdata_q[OSC_DIS_BIT] <= oscDisable_q;
                REG_COMBO_SEL_ONE: rdata_q <= comboSelOne_q;
                REG_COMBO_SEL_TWO: rdata_q <= comboSelTwo_q;
                REG_PORT_B_OPT:
                begin
                    rdata_q[WAKE_COMBO_BIT] <= wakeOpt_q;
                    rdata_q[PORT_B_PULL_BIT] <= portBPull_q;
                end
                REG_PORT_C_STROBE: rdata_q[STROBE_SEL_LSB +: STROBE_SEL_W] <= strobeSel_q;
                default: ;
            endcase
        end
    end

    // ==========================================
    // checks
    sequence s_unguarded;
        busIn.wr && busIn.addr == REG_SYS_CTL_ONE && busIn.wdata[SLEEP_BIT] && !guard_q;
    endsequence

    sequence s_wake;
        mode_q == MODE_SLEEP ##1 mode_q == MODE_ACTIVE;
    endsequence

    property p_guard;
        @(posedge mclk) disable iff (!resetn)
        (mode_q == MODE_ACTIVE) ##0 s_unguarded |=> mode_q == MODE_ACTIVE;
    endproperty
    a_guard: assert property (p_guard) else $error("unguarded sleep write took effect");

    property p_sleep_outputs;
        @(posedge mclk) disable iff (!resetn)
        mode_q == MODE_SLEEP |=> !sleepCtl_q.oscEnable && sleepCtl_q.portBHighZ
            && !sleepCtl_q.interruptsOn && sysReset_q;
    endproperty
    a_sleep_outputs: assert property (p_sleep_outputs) else $error("sleep outputs wrong");

    property p_wake_flags;
        @(posedge mclk) disable iff (!resetn)
        s_wake |-> !sleepFlag_q && guard_q && sysReset_q && cpuReset_q;
    endproperty
    a_wake_flags: assert property (p_wake_flags) else $error("wake flags wrong");

    property p_source_reset;
        @(posedge mclk) disable iff (!resetn)
        (wdogReset || oscLost_q || pinHeld || comboHeld) |=> sysReset_q ##1 cpuReset_q;
    endproperty
    a_source_reset: assert property (p_source_reset) else $error("source missed reset");

    property p_cpu_after_sys;
        @(posedge mclk) disable iff (!resetn)
        $fell(sysReset_q) |-> cpuReset_q && cpuCnt_q == DELAY_LOAD;
    endproperty
    a_cpu_after_sys: assert property (p_cpu_after_sys) else $error("cpu delay not loaded");

    property p_cpu_release;
        @(posedge mclk) disable iff (!resetn)
        $fell(cpuReset_q) |-> !$past(sysReset_q) && $past(cpuCnt_q) == '0;
    endproperty
    a_cpu_release: assert property (p_cpu_release) else $error("cpu reset left early");

    property p_strobe;
        @(posedge mclk) disable iff (!resetn)
        strobeSel_q == STROBE_SHOWS_RESET ##1 strobeSel_q == STROBE_SHOWS_RESET
            |-> strobePin_q == $past(cpuReset_q);
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe not showing reset");

    property p_supervisor_reenable;
        @(posedge mclk) disable iff (!resetn)
        sysReset_q |=> !oscDisable_q;
    endproperty
    a_supervisor_reenable: assert property (p_supervisor_reenable) else $error("supervisor stays off");

    property p_combo_wake;
        @(posedge mclk) disable iff (!resetn)
        mode_q == MODE_SLEEP && comboMatch_q && wakeOpt_q |=> mode_q == MODE_ACTIVE ##1 sysReset_q;
    endproperty
    a_combo_wake: assert property (p_combo_wake) else $error("combination did not wake");

endmodule : rss_reset_sleep_sequencer

// >>> dv/rss_far_side.sv
// rss_far_side: oscillator tap, reset pin and port line levels
// assumes bench supplies pin levels and oscillator run request
`timescale 1ns/1ps
module rss_far_side
(
    // clock and control
    input wire logic mclk,
    input wire logic oscRun,
    input wire logic pinLevel,
    input wire logic [3:0] lineLevel,
    // pins
    output logic systemClockTap,
    output logic resetPin,
    output logic [3:0] inputPortLine
);
    // ==========================================
    // tap, period 8 mclk, stands still when stopped
    logic [1:0] divCnt_q = 2'h0;
    logic tapLevel_q = 1'b0;
    always_ff @(posedge mclk)
    begin
        divCnt_q <= divCnt_q + 2'h1;
        if (oscRun && divCnt_q == 2'h3)
        begin
            tapLevel_q <= ~tapLevel_q;
        end
    end
    assign systemClockTap = tapLevel_q;
    assign resetPin = pinLevel;
    assign inputPortLine = lineLevel;
endmodule : rss_far_side

// >>> dv/tb_rss_reset_sleep_sequencer.sv
// tb_rss_reset_sleep_sequencer: register calls and pin stimulus with checks
// assumes shortened counts and an 8-cycle system tick from the far side
`timescale 1ns/1ps
module tb_rss_reset_sleep_sequencer
    import rss_pkg::*;
;
    localparam int DEB = 20;
    localparam int WK = 8;
    localparam int OSCL = 40;
    logic mclk, resetn, runEn, pinLevel, wdogReset, strobeData;
    logic tap, pin, sysReset_q, cpuReset_q, strobePin_q, sleepMode_q;
    logic [3:0] lineLevel, lines;
    logic [DATA_W-1:0] rdata_q;
    rss_bus_s busIn;
    rss_sleep_ctl_s sleepCtl_q;
    int errTotal = 0;
    int testsRun = 0;
    int cycles = 0;
    rss_reset_sleep_sequencer #(.OR_TYPE(1'b0), .DEBOUNCE_CYCLES(DEB), .WAKE_CYCLES(WK),
        .OSC_LOSS_CYCLES(OSCL), .CPU_DELAY(4), .SYS_HOLD(2)) DUT (.mclk(mclk),
        .resetn(resetn), .busIn(busIn), .rdata_q(rdata_q), .resetPin(pin),
        .inputPortLine(lines), .systemClockTap(tap), .wdogReset(wdogReset),
        .strobeData(strobeData), .sysReset_q(sysReset_q), .cpuReset_q(cpuReset_q),
        .strobePin_q(strobePin_q), .sleepMode_q(sleepMode_q), .sleepCtl_q(sleepCtl_q));
    rss_far_side farSide (.mclk(mclk), .oscRun(runEn && !sleepMode_q), .pinLevel(pinLevel),
        .lineLevel(lineLevel), .systemClockTap(tap), .resetPin(pin), .inputPortLine(lines));
    // ==========================================
    // tasks
    task summarize;
        $display("counts: %0d compares, %0d mismatches", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0)
        begin
            $display("Regression OK");
        end
        else
        begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    task chkBit(input logic got, input logic exp);
        testsRun++;
        if (got !== exp)
        begin
            errTotal++;
            $display("Error %0t: bit got %b exp %b", $time, got, exp);
        end
    endtask : chkBit
    task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        busIn <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        busIn.wr <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task rdChk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        busIn <= '{addr: a, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        busIn.rd <= 1'b0;
        #1;
        testsRun++;
        if (rdata_q !== e)
        begin
            errTotal++;
            $display("Error %0t: read got %h exp %h", $time, rdata_q, e);
        end
        @(posedge mclk);
    endtask : rdChk
    task waitCyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : waitCyc
    // sel 0 system reset, 1 cpu reset, 2 sleep mode
    task waitSig(input int sel, input logic v, input int lim);
        logic s;
        for (int n = 0; n < lim; n++)
        begin
            s = (sel == 0) ? sysReset_q : (sel == 1) ? cpuReset_q : sleepMode_q;
            if (s === v)
            begin
                break;
            end
            @(posedge mclk);
        end
        chkBit(s, v);
    endtask : waitSig
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errTotal++;
            summarize();
        end
    end
    // ==========================================
    // tests
    initial
    begin
        busIn = '0;
        resetn = 1'b0;
        runEn = 1'b1;
        pinLevel = 1'b0;
        lineLevel = 4'h0;
        wdogReset = 1'b0;
        strobeData = 1'b1;
        repeat (2) @(posedge mclk);
        chkBit(sysReset_q, 1'b1);
        chkBit(cpuReset_q, 1'b1);
        resetn <= 1'b1;
        waitSig(0, 1'b0, 100);
        chkBit(cpuReset_q, 1'b1);
        waitSig(1, 1'b0, 100);
        waitCyc(1);
        chkBit(strobePin_q, 1'b0);
        rdChk(REG_SYS_CTL_TWO, 4'h0);
        wr(REG_PORT_C_STROBE, 4'h1);
        waitCyc(1);
        chkBit(strobePin_q, 1'b1);
        rdChk(REG_PORT_C_STROBE, 4'h1);
        wr(REG_PORT_C_STROBE, 4'h0);
        $display("test power-up done");
        wr(REG_SYS_CTL_ONE, 4'h1);
        waitCyc(4);
        chkBit(sleepMode_q, 1'b0);
        wr(REG_SYS_CTL_TWO, 4'h4);
        wr(REG_SYS_CTL_ONE, 4'h1);
        waitSig(2, 1'b1, 5);
        waitCyc(2);
        chkBit(sysReset_q, 1'b1);
        chkBit(sleepCtl_q.oscEnable, 1'b0);
        chkBit(sleepCtl_q.portBHighZ, 1'b1);
        chkBit(sleepCtl_q.portAEnable, 1'b0);
        chkBit(sleepCtl_q.interruptsOn | sleepCtl_q.oscSupervisorOn, 1'b0);
        chkBit(sleepCtl_q.portBPull | sleepCtl_q.portAPullDown, 1'b0);
        pinLevel <= 1'b1;
        waitCyc(4);
        pinLevel <= 1'b0;
        waitCyc(12);
        chkBit(sleepMode_q, 1'b1);
        pinLevel <= 1'b1;
        waitSig(2, 1'b0, WK + 10);
        pinLevel <= 1'b0;
        chkBit(cpuReset_q, 1'b1);
        waitSig(1, 1'b0, 150);
        rdChk(REG_SYS_CTL_TWO, 4'h4);
        rdChk(REG_SYS_CTL_ONE, 4'h0);
        $display("test sleep and pin wake done");
        pinLevel <= 1'b1;
        waitCyc(10);
        pinLevel <= 1'b0;
        waitCyc(DEB);
        chkBit(sysReset_q, 1'b0);
        pinLevel <= 1'b1;
        waitCyc(DEB - 2);
        chkBit(sysReset_q, 1'b0);
        waitSig(0, 1'b1, 14);
        pinLevel <= 1'b0;
        waitSig(1, 1'b1, 4);
        waitSig(1, 1'b0, 150);
        wdogReset <= 1'b1;
        @(posedge mclk);
        wdogReset <= 1'b0;
        waitSig(0, 1'b1, 4);
        waitSig(1, 1'b1, 4);
        waitSig(1, 1'b0, 150);
        rdChk(REG_SYS_CTL_TWO, 4'h4);
        $display("test pin and watchdog resets done");
        runEn <= 1'b0;
        waitSig(0, 1'b1, OSCL + 20);
        runEn <= 1'b1;
        waitSig(0, 1'b0, 150);
        chkBit(cpuReset_q, 1'b1);
        waitSig(1, 1'b0, 150);
        wr(REG_SYS_CTL_THREE, 4'h2);
        runEn <= 1'b0;
        waitCyc(OSCL + 20);
        chkBit(sysReset_q, 1'b0);
        runEn <= 1'b1;
        wdogReset <= 1'b1;
        @(posedge mclk);
        wdogReset <= 1'b0;
        waitSig(1, 1'b1, 4);
        rdChk(REG_SYS_CTL_THREE, 4'h0);
        waitSig(1, 1'b0, 150);
        $display("test oscillation supervisor done");
        for (int c = 0; c < 4; c++)
        begin
            lineLevel <= (c == 2) ? 4'h0 : 4'h1;
            wr(REG_COMBO_SEL_ONE, {3'b111, c[1]});
            wr(REG_COMBO_SEL_TWO, {3'b111, c[0]});
            waitCyc(DEB + 10);
            chkBit(sysReset_q, c != 0);
            wr(REG_COMBO_SEL_ONE, 4'h0);
            wr(REG_COMBO_SEL_TWO, 4'h0);
            waitSig(1, 1'b0, 150);
        end
        $display("test port combination done");
        lineLevel <= 4'h0;
        wr(REG_PORT_B_OPT, 4'h3);
        wr(REG_COMBO_SEL_ONE, 4'he);
        wr(REG_COMBO_SEL_TWO, 4'hf);
        wr(REG_SYS_CTL_ONE, 4'h1);
        waitSig(2, 1'b1, 5);
        waitCyc(2);
        chkBit(sleepCtl_q.portAEnable, 1'b1);
        chkBit(sleepCtl_q.portAPullDown, 1'b1);
        chkBit(sleepCtl_q.portBPull, 1'b1);
        lineLevel <= 4'h1;
        waitSig(2, 1'b0, 10);
        lineLevel <= 4'h0;
        waitSig(1, 1'b0, 150);
        rdChk(REG_PORT_B_OPT, 4'h3);
        rdChk(REG_COMBO_SEL_TWO, 4'hf);
        $display("test combination wake done");
        summarize();
    end
endmodule : tb_rss_reset_sleep_sequencer
